// file: design/protection_state_arbiter_defines.vh
// Constants for the battery protection decision logic.
// Assumes a 25 MHz system clock; times are in their own units.
`ifndef PROTECTION_STATE_ARBITER_DEFINES_VH
`define PROTECTION_STATE_ARBITER_DEFINES_VH

// Clock rate in kHz, keeps products below two to the thirty-first
`define CLK_KHZ 25000

// Width of every delay counter
`define DLY_W 26

// Right shift applied to counter delays in shortening mode
`define TEST_SHIFT 6

// Delay times, plain defaults
`define OVC_DET_MS 1000
`define OVC_REL_MS 16
`define OVD_DET_MS 125
`define OVD_REL_MS 16
`define OCUR_DET_MS 8
`define OCUR_REL_MS 2
`define XCHG_DET_MS 16
`define XCHG_REL_MS 16
`define SHORT_DET_US 300

// Cycle counts derived from the times, least times round up
`define MS_TO_CYC(ms) ((ms) * `CLK_KHZ)
`define US_TO_CYC(us) ((((us) * `CLK_KHZ) + 999) / 1000)
`define OVC_DET_CYC `MS_TO_CYC(`OVC_DET_MS)
`define OVC_REL_CYC `MS_TO_CYC(`OVC_REL_MS)
`define OVD_DET_CYC `MS_TO_CYC(`OVD_DET_MS)
`define OVD_REL_CYC `MS_TO_CYC(`OVD_REL_MS)
`define OCUR_DET_CYC `MS_TO_CYC(`OCUR_DET_MS)
`define OCUR_REL_CYC `MS_TO_CYC(`OCUR_REL_MS)
`define XCHG_DET_CYC `MS_TO_CYC(`XCHG_DET_MS)
`define XCHG_REL_CYC `MS_TO_CYC(`XCHG_REL_MS)
`define SHORT_DET_CYC `US_TO_CYC(`SHORT_DET_US)

// Bit positions in the synchroniser vector
`define SYN_OVC 0
`define SYN_OVD 1
`define SYN_OCUR 2
`define SYN_SHORT 3
`define SYN_XCHG 4
`define SYN_STBY 5
`define SYN_TEST 6
`define SYN_W 7

// Reset value of the synchroniser vector
`define SYN_RST 7'h00

`endif

// file: design/delay_timer.v
// One delay counter for a detection or release delay.
// Assumes run and target come from logic on clk_sys.
`timescale 1ns/1ps

module delay_timer #(
    parameter W = 26
) (
    clk_sys,
    rst_n,
    run,
    target,
    done
);
    input wire clk_sys;
    input wire rst_n;
    input wire run;
    input wire [W-1:0] target;
    output reg done;

    reg [W-1:0] cnt_r;

    ////////////////////////////////////////////////////////////////////
    // Count while run is high, pulse done after target cycles
    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            cnt_r <= {W{1'b0}};
            done <= 1'b0;
        end else if (!run) begin
            cnt_r <= {W{1'b0}};
            done <= 1'b0;
        end else if (cnt_r >= target - {{(W-1){1'b0}}, 1'b1}) begin
            cnt_r <= {W{1'b0}};
            done <= 1'b1;
        end else begin
            cnt_r <= cnt_r + {{(W-1){1'b0}}, 1'b1};
            done <= 1'b0;
        end
    end
endmodule

// file: design/protection_state_arbiter.v
// Decision logic of a two-cell battery protection device.
// Assumes comparator results and the test pin arrive asynchronously
// and that the test pin reads low when left open.
`timescale 1ns/1ps
`include "protection_state_arbiter_defines.vh"

// Notes on behaviour
// - Test pin high shortens every counter-made delay except short-circuit detection.
// - Test pin open or low keeps full-length counter delays.
// - Short-circuit delay is not counter-scaled and ignores the test pin.
// - Overcharge detection in progress wins over a new over-discharge.
// - Over-discharge detection resumes after overcharge completes if still true.
// - Overcharge completed first leaves the minus node with no pull.
// - Over-discharge after overcharge: pull-up on, no standby.
// - Overcharge and over-current run in parallel; overcharge keeps counting.
// - Established overcharge aborts a pending over-current detection.
// - Over-current completed first enables the pull-down path.
// - Overcharge arising suspends over-discharge detection, overcharge first.
// - Over-discharge and over-current run in parallel; over-discharge continues.
// - Established over-discharge aborts a pending over-current detection.
// - Completed over-discharge switches to pull-up and enters standby unless overcharge is held.
// - Short-circuit detection runs independently of all other detections.
// - Excessive charger blocked during discharge faults; delay starts after.
// - Overcharge detected after its delay drives the charge gate low.
// - Over-discharge detected after its delay drives the discharge gate low.
// - Over-current detected after its delay drives discharge gate low, no standby.
module protection_state_arbiter #(
    parameter [`DLY_W-1:0] OVC_DET_CYC = `OVC_DET_CYC,
    parameter [`DLY_W-1:0] OVC_REL_CYC = `OVC_REL_CYC,
    parameter [`DLY_W-1:0] OVD_DET_CYC = `OVD_DET_CYC,
    parameter [`DLY_W-1:0] OVD_REL_CYC = `OVD_REL_CYC,
    parameter [`DLY_W-1:0] OCUR_DET_CYC = `OCUR_DET_CYC,
    parameter [`DLY_W-1:0] OCUR_REL_CYC = `OCUR_REL_CYC,
    parameter [`DLY_W-1:0] XCHG_DET_CYC = `XCHG_DET_CYC,
    parameter [`DLY_W-1:0] XCHG_REL_CYC = `XCHG_REL_CYC,
    parameter [`DLY_W-1:0] SHORT_DET_CYC = `SHORT_DET_CYC
) (
    clk_sys,
    rst_n,
    cmp_ovc,
    cmp_ovd,
    cmp_ocur,
    cmp_short,
    cmp_xchg,
    cmp_stby_rel,
    test_mode_pin,
    chg_gate_r,
    dis_gate_r,
    pull_up_en_r,
    pull_down_en_r,
    standby_r
);
    input wire clk_sys;
    input wire rst_n;
    input wire cmp_ovc;
    input wire cmp_ovd;
    input wire cmp_ocur;
    input wire cmp_short;
    input wire cmp_xchg;
    input wire cmp_stby_rel;
    input wire test_mode_pin;
    output reg chg_gate_r;
    output reg dis_gate_r;
    output reg pull_up_en_r;
    output reg pull_down_en_r;
    output reg standby_r;

    ////////////////////////////////////////////////////////////////////
    // Delay scaling for shortening mode, never below one cycle
    function [`DLY_W-1:0] scaled;
        input [`DLY_W-1:0] n;
        input shorten;
        reg [`DLY_W-1:0] s;
        begin
            s = n;
            if (shorten) begin
                s = n >> `TEST_SHIFT;
            end
            if (s == {`DLY_W{1'b0}}) begin
                s = {{(`DLY_W-1){1'b0}}, 1'b1};
            end
            scaled = s;
        end
    endfunction

    ////////////////////////////////////////////////////////////////////
    // Input synchronisers, two stages for every pin
    reg [`SYN_W-1:0] sync1_r;
    reg [`SYN_W-1:0] sync2_r;
    wire [`SYN_W-1:0] pins;

    assign pins = {test_mode_pin, cmp_stby_rel, cmp_xchg, cmp_short,
                   cmp_ocur, cmp_ovd, cmp_ovc};

    // First stage is read only by the second
    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            sync1_r <= `SYN_RST;
            sync2_r <= `SYN_RST;
        end else begin
            sync1_r <= pins;
            sync2_r <= sync1_r;
        end
    end

    wire ovc_s = sync2_r[`SYN_OVC];
    wire ovd_s = sync2_r[`SYN_OVD];
    wire ocur_s = sync2_r[`SYN_OCUR];
    wire short_s = sync2_r[`SYN_SHORT];
    wire xchg_s = sync2_r[`SYN_XCHG];
    wire stby_s = sync2_r[`SYN_STBY];
    wire test_s = sync2_r[`SYN_TEST];

    ////////////////////////////////////////////////////////////////////
    // Detection state
    reg ovc_det_r;
    reg ovd_det_r;
    reg ocur_det_r;
    reg short_det_r;
    reg xchg_det_r;
    reg stby_st_r;

    wire ovc_done;
    wire ovd_done;
    wire ocur_done;
    wire short_done;
    wire orel_done;
    wire xchg_done;

    // Overcharge counting toward detection
    wire ovc_busy = ovc_s & ~ovc_det_r;
    // Any discharge-side fault held or in detection
    wire dis_fault = ovd_det_r | ocur_det_r | short_det_r;
    wire dis_pending = (ovd_s & ~ovd_det_r) | (ocur_s & ~ocur_det_r) |
                       (short_s & ~short_det_r);

    ////////////////////////////////////////////////////////////////////
    // Timer run conditions and targets
    wire ovc_run = ovc_det_r ? ~ovc_s : ovc_s;
    wire [`DLY_W-1:0] ovc_tgt =
        scaled(ovc_det_r ? OVC_REL_CYC : OVC_DET_CYC, test_s);

    // Over-discharge waits while overcharge is counting
    wire ovd_run = ovd_det_r ? (~ovd_s & ~stby_st_r)
                             : (ovd_s & ~ovc_busy);
    wire [`DLY_W-1:0] ovd_tgt =
        scaled(ovd_det_r ? OVD_REL_CYC : OVD_DET_CYC, test_s);

    // Over-current dropped once overcharge or over-discharge holds
    wire ocur_run = ocur_s & ~ocur_det_r & ~ovc_det_r &
                    ~ovd_det_r;
    wire [`DLY_W-1:0] ocur_tgt = scaled(OCUR_DET_CYC, test_s);

    // Short circuit has a fixed delay and no blocking term
    wire short_run = short_s & ~short_det_r;
    wire [`DLY_W-1:0] short_tgt = SHORT_DET_CYC;

    // Shared release of over-current and short circuit
    wire orel_run = (ocur_det_r | short_det_r) & ~ocur_s & ~short_s;
    wire [`DLY_W-1:0] orel_tgt = scaled(OCUR_REL_CYC, test_s);

    // Excessive charger detection counts only outside discharge faults
    wire xchg_run = xchg_det_r ? ~xchg_s
                               : (xchg_s & ~dis_fault &
                                  ~dis_pending);
    wire [`DLY_W-1:0] xchg_tgt =
        scaled(xchg_det_r ? XCHG_REL_CYC : XCHG_DET_CYC, test_s);

    ////////////////////////////////////////////////////////////////////
    // Delay counters
    delay_timer #(.W(`DLY_W)) u_ovc_tmr (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .run(ovc_run),
        .target(ovc_tgt),
        .done(ovc_done)
    );

    delay_timer #(.W(`DLY_W)) u_ovd_tmr (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .run(ovd_run),
        .target(ovd_tgt),
        .done(ovd_done)
    );

    delay_timer #(.W(`DLY_W)) u_ocur_tmr (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .run(ocur_run),
        .target(ocur_tgt),
        .done(ocur_done)
    );

    delay_timer #(.W(`DLY_W)) u_short_tmr (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .run(short_run),
        .target(short_tgt),
        .done(short_done)
    );

    delay_timer #(.W(`DLY_W)) u_orel_tmr (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .run(orel_run),
        .target(orel_tgt),
        .done(orel_done)
    );

    delay_timer #(.W(`DLY_W)) u_xchg_tmr (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .run(xchg_run),
        .target(xchg_tgt),
        .done(xchg_done)
    );

    ////////////////////////////////////////////////////////////////////
    // Overcharge detect and release
    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            ovc_det_r <= 1'b0;
        end else if (ovc_done & ovc_run) begin
            ovc_det_r <= ~ovc_det_r;
        end
    end

    // Over-discharge detect and release
    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            ovd_det_r <= 1'b0;
        end else if (ovd_done & ovd_run) begin
            ovd_det_r <= ~ovd_det_r;
        end
    end

    // Standby entry on over-discharge, left by a charger
    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            stby_st_r <= 1'b0;
        end else if (ovd_done & ovd_run & ~ovd_det_r) begin
            stby_st_r <= ~ovc_det_r;
        end else if (stby_st_r & stby_s) begin
            stby_st_r <= 1'b0;
        end
    end

    // Over-current detect; release shared with short circuit
    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            ocur_det_r <= 1'b0;
        end else if (ocur_done & ocur_run) begin
            ocur_det_r <= 1'b1;
        end else if (orel_done & orel_run) begin
            ocur_det_r <= 1'b0;
        end
    end

    // Short-circuit detect and release
    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            short_det_r <= 1'b0;
        end else if (short_done & short_run) begin
            short_det_r <= 1'b1;
        end else if (orel_done & orel_run) begin
            short_det_r <= 1'b0;
        end
    end

    // Excessive charger detect and release
    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            xchg_det_r <= 1'b0;
        end else if (xchg_done & xchg_run) begin
            xchg_det_r <= ~xchg_det_r;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Gate and pull outputs, one cycle behind the state
    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            chg_gate_r <= 1'b1;
            dis_gate_r <= 1'b1;
            pull_up_en_r <= 1'b0;
            pull_down_en_r <= 1'b0;
            standby_r <= 1'b0;
        end else begin
            chg_gate_r <= ~(ovc_det_r | xchg_det_r);
            dis_gate_r <= ~dis_fault;
            pull_up_en_r <= ovd_det_r;
            // Pull-down only for current faults without over-discharge
            pull_down_en_r <= (ocur_det_r | short_det_r) &
                              ~ovd_det_r;
            standby_r <= stby_st_r;
        end
    end
endmodule

// file: verification/psa_props.sv
// Checker for the protection decision outputs.
// Assumes it is bound to protection_state_arbiter.
`timescale 1ns/1ps
module psa_props (
    input wire clk_sys,
    input wire rst_n,
    input wire cmp_ovc,
    input wire cmp_ovd,
    input wire cmp_ocur,
    input wire cmp_short,
    input wire cmp_xchg,
    input wire test_mode_pin,
    input wire chg_gate_r,
    input wire dis_gate_r,
    input wire pull_up_en_r,
    input wire pull_down_en_r,
    input wire standby_r
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    ////////////////////////////////////////////////////////////////////////
    // Gate drops need a cause held at the comparators
    property p_chg_fall;
        $fell(chg_gate_r) |-> $past(cmp_ovc, 5) || $past(cmp_xchg, 5);
    endproperty
    a_chg_fall: assert property (p_chg_fall)
        else $error("charge gate fell without cause");
    property p_dis_fall;
        $fell(dis_gate_r) |->
            $past(cmp_ovd, 5) || $past(cmp_ocur, 5) || $past(cmp_short, 5);
    endproperty
    a_dis_fall: assert property (p_dis_fall)
        else $error("discharge gate fell without cause");
    // Pull paths and standby
    property p_stby;
        $rose(standby_r) |-> !dis_gate_r && pull_up_en_r;
    endproperty
    a_stby: assert property (p_stby)
        else $error("standby without pull-up");
    property p_pd;
        pull_down_en_r |-> !dis_gate_r && !standby_r;
    endproperty
    a_pd: assert property (p_pd)
        else $error("pull-down in wrong state");
    property p_excl;
        !(pull_up_en_r && pull_down_en_r);
    endproperty
    a_excl: assert property (p_excl)
        else $error("both pull paths on");
    property p_pull;
        (pull_up_en_r || pull_down_en_r) |-> !dis_gate_r;
    endproperty
    a_pull: assert property (p_pull)
        else $error("pull path with discharge gate on");
    // Delay lengths and excessive charger blocking
    property p_ovc_dly;
        $rose(cmp_ovc) && !test_mode_pin && chg_gate_r && !cmp_xchg
            |=> chg_gate_r [*8];
    endproperty
    a_ovc_dly: assert property (p_ovc_dly)
        else $error("overcharge delay too short");
    property p_short_dly;
        $rose(cmp_short) && dis_gate_r && !cmp_ocur && !cmp_ovd
            |=> dis_gate_r [*8];
    endproperty
    a_short_dly: assert property (p_short_dly)
        else $error("short delay too short");
    property p_xchg;
        $fell(chg_gate_r) && !$past(cmp_ovc, 5) |-> $past(dis_gate_r, 3);
    endproperty
    a_xchg: assert property (p_xchg)
        else $error("charger fault during discharge fault");
endmodule
bind protection_state_arbiter psa_props psa_props_inst (
    .clk_sys(clk_sys), .rst_n(rst_n), .cmp_ovc(cmp_ovc),
    .cmp_ovd(cmp_ovd), .cmp_ocur(cmp_ocur), .cmp_short(cmp_short),
    .cmp_xchg(cmp_xchg), .test_mode_pin(test_mode_pin),
    .chg_gate_r(chg_gate_r), .dis_gate_r(dis_gate_r),
    .pull_up_en_r(pull_up_en_r), .pull_down_en_r(pull_down_en_r),
    .standby_r(standby_r));

// file: verification/fet_pack_model.sv
// Far side: FET pair, pack load and charger seen at the minus node.
// Assumes gate levels come straight from the decision block.
`timescale 1ns/1ps
module fet_pack_model (
    input wire chg_gate,
    input wire dis_gate,
    input wire load_heavy,
    input wire load_short,
    input wire charger_on,
    input wire charger_hot,
    output wire path_on,
    output wire cmp_ocur,
    output wire cmp_short,
    output wire cmp_xchg,
    output wire cmp_stby_rel
);
    // Current flows only with both FETs on
    assign path_on = chg_gate & dis_gate;
    // A load keeps the minus node high until it is removed
    assign cmp_ocur = load_heavy;
    assign cmp_short = load_short;
    // A charger drags the minus node low
    assign cmp_xchg = charger_hot;
    assign cmp_stby_rel = charger_on | charger_hot;
endmodule

// file: verification/tb_top.sv
// Self-checking bench for the protection decision logic.
// Assumes the far-side model drives the load and charger comparators.
`timescale 1ns/1ps
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin \
    err_count++; $display("[ERR] %0t got %b exp %b", $time, a, b); end end
module tb_top;
    localparam [25:0] OVC = 26'h64, REL = 26'h28, OVD = 26'h3c;
    localparam [25:0] OC = 26'h32, OCR = 26'h1e, SC = 26'h14;
    localparam [4:0] IDLE = 5'h18, OVCD = 5'h08, OVDD = 5'h15, OCD = 5'h12;
    logic clk_sys, rst_n, cmp_ovc, cmp_ovd, test_mode_pin;
    logic load_heavy, load_short, charger_on, charger_hot;
    wire cmp_ocur, cmp_short, cmp_xchg, cmp_stby_rel, path_on;
    wire chg_gate_r, dis_gate_r, pull_up_en_r, pull_down_en_r, standby_r;
    wire [4:0] out_v = {chg_gate_r, dis_gate_r, pull_up_en_r,
        pull_down_en_r, standby_r};
    int err_count = 0, samples_checked = 0, cyc = 0, k;
    protection_state_arbiter #(.OVC_DET_CYC(OVC), .OVC_REL_CYC(REL),
        .OVD_DET_CYC(OVD), .OVD_REL_CYC(REL), .OCUR_DET_CYC(OC),
        .OCUR_REL_CYC(OCR), .XCHG_DET_CYC(REL), .XCHG_REL_CYC(REL),
        .SHORT_DET_CYC(SC)) protection_state_arbiter_inst (
        .clk_sys(clk_sys), .rst_n(rst_n), .cmp_ovc(cmp_ovc),
        .cmp_ovd(cmp_ovd), .cmp_ocur(cmp_ocur), .cmp_short(cmp_short),
        .cmp_xchg(cmp_xchg), .cmp_stby_rel(cmp_stby_rel),
        .test_mode_pin(test_mode_pin), .chg_gate_r(chg_gate_r),
        .dis_gate_r(dis_gate_r), .pull_up_en_r(pull_up_en_r),
        .pull_down_en_r(pull_down_en_r), .standby_r(standby_r));
    fet_pack_model fet_pack_model_inst (.chg_gate(chg_gate_r),
        .dis_gate(dis_gate_r), .load_heavy(load_heavy),
        .load_short(load_short), .charger_on(charger_on),
        .charger_hot(charger_hot), .path_on(path_on), .cmp_ocur(cmp_ocur),
        .cmp_short(cmp_short), .cmp_xchg(cmp_xchg),
        .cmp_stby_rel(cmp_stby_rel));
    ////////////////////////////////////////////////////////////////////////
    // Clock and hang limit
    initial begin
        clk_sys = 0;
        forever #20 clk_sys = ~clk_sys;
    end
    always @(posedge clk_sys) begin
        cyc++;
        if (cyc == 20000) begin
            err_count++;
            test_done();
        end
    end
    ////////////////////////////////////////////////////////////////////////
    // Reference delay: counter delays scaled in shortening mode
    function automatic int dly(int n, logic s);
        return s ? ((n >> 6) < 1 ? 1 : (n >> 6)) : n;
    endfunction
    // Waits for an output pattern, N+3 edges within two either side
    task wait_out(input logic [4:0] e, input int n, input string s);
        k = 0;
        while (out_v !== e && k < n + 5) begin
            @(negedge clk_sys);
            k++;
        end
        `CHK(out_v, e)
        `CHK(k >= n + 1, 1'b1)
        $display("step done: %s", s);
    endtask
    task test_done;
        $display("checks %0d errors %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        {rst_n, cmp_ovc, cmp_ovd, load_heavy, load_short} = 5'h00;
        {charger_on, charger_hot} = 2'h0;
        test_mode_pin = 0;
        void'($urandom(32'hdac3));
        repeat (5) @(negedge clk_sys);
        rst_n = 1;
        @(negedge clk_sys);
        `CHK(out_v, IDLE)
        `CHK(path_on, 1'b1)
        cmp_ovc = 1;
        wait_out(OVCD, OVC, "overcharge");
        cmp_ovc = 0;
        wait_out(IDLE, REL, "overcharge release");
        test_mode_pin = 1;
        cmp_ovc = 1;
        wait_out(OVCD, dly(OVC, 1), "short overcharge");
        cmp_ovc = 0;
        wait_out(IDLE, dly(REL, 1), "short release");
        load_short = 1;
        wait_out(OCD, SC, "short circuit");
        load_short = 0;
        wait_out(IDLE, dly(OCR, 1), "short clear");
        test_mode_pin = 0;
        cmp_ovd = 1;
        wait_out(OVDD, OVD, "over-discharge");
        charger_on = 1;
        repeat (8) @(negedge clk_sys);
        `CHK(standby_r, 1'b0)
        cmp_ovd = 0;
        wait_out(IDLE, REL, "over-discharge release");
        charger_on = 0;
        load_heavy = 1;
        wait_out(OCD, OC, "over-current");
        charger_hot = 1;
        repeat (REL + 10) @(negedge clk_sys);
        `CHK(out_v, OCD)
        load_heavy = 0;
        wait_out(IDLE, OCR, "over-current release");
        wait_out(OVCD, REL, "hot charger");
        charger_hot = 0;
        wait_out(IDLE, REL, "hot charger release");
        cmp_ovd = 1;
        repeat (OVD / 2) @(negedge clk_sys);
        cmp_ovc = 1;
        wait_out(OVCD, OVC, "overcharge wins");
        wait_out(5'h04, OVD - 1, "over-discharge resumed");
        {cmp_ovc, cmp_ovd} = 2'h0;
        wait_out(IDLE, REL, "both released");
        {cmp_ovc, load_heavy} = 2'h3;
        wait_out(OCD, OC, "over-current first");
        wait_out(5'h02, OVC - OC - 2, "overcharge parallel");
        load_heavy = 0;
        wait_out(OVCD, OCR, "load removed");
        load_heavy = 1;
        repeat (OC + 10) @(negedge clk_sys);
        `CHK(out_v, OVCD)
        {cmp_ovc, load_heavy} = 2'h0;
        wait_out(IDLE, REL, "parallel release");
        // Random glitches shorter than the delay must not count
        repeat (4) begin
            cmp_ovd = 1;
            repeat ($urandom_range(OVD - 10, 1)) @(negedge clk_sys);
            cmp_ovd = 0;
            repeat (3) @(negedge clk_sys);
        end
        repeat (OVD + 8) @(negedge clk_sys);
        `CHK(out_v, IDLE)
        // Over-current finishes first, over-discharge still completes
        {cmp_ovd, load_heavy} = 2'h3;
        wait_out(OCD, OC, "over-current lead");
        wait_out(OVDD, OVD - OC - 2, "over-discharge after");
        {cmp_ovd, load_heavy} = 2'h0;
        charger_on = 1;
        wait_out(IDLE, REL + 2, "charger release");
        charger_on = 0;
        test_done();
    end
endmodule
